// File: rtl/slp_pkg.sv
// package: constants shared by the lane port host and its fifo
package slp_pkg;

  // ****************************************************************
  // lane and bus widths
  // ****************************************************************
  localparam int LANE_W          = 64;
  localparam int LANES_40G       = 4;
  localparam int LANES_50G       = 2;
  localparam int VIRTUAL_LANES   = 4;   // virtual_lane_count
  localparam int USER_W_STRADDLE = 128;
  localparam int USER_W_WIDE     = 256;
  localparam int FIFO_DEPTH      = 8;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  // least time the core clock must run before the path resets drop
  localparam int STABLE_TIME_NS  = 1000;
  localparam int STABLE_CYCLES   =
    (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STABLE_CNT_W    = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [LANE_W-1:0] IDLE_WORD = 64'h0000_0000_0000_0000;

endpackage

// File: rtl/slp_fifo.sv
// dual-clock fifo with gray-coded pointers and valid/ready on both sides
`timescale 1ns/1ps
module slp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic             wrClk,
  input  wire logic             wrReset,
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  wrReady,
  input  wire logic             rdClk,
  input  wire logic             rdReset,
  output logic                  rdValid,
  output logic      [WIDTH-1:0] rdData,
  input  wire logic             rdReady
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_badDepth
      $error("slp_fifo: DEPTH must be a power of two, at least 4");
    end
  endgenerate

  function automatic logic [AW:0] toGray(input logic [AW:0] b);
    toGray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrBin_r;
  logic [AW:0]      wrGray_r;
  logic [AW:0]      rdBin_r;
  logic [AW:0]      rdGray_r;
  logic [AW:0]      rdGrayS1_r;
  logic [AW:0]      rdGrayS2_r;
  logic [AW:0]      wrGrayS1_r;
  logic [AW:0]      wrGrayS2_r;
  logic             wrReady_r;
  logic             rdValid_r;

  // ****************************************************************
  // write side
  // ****************************************************************
  wire logic        doWrite  = wrValid & wrReady_r;
  wire logic [AW:0] wrBinNxt = wrBin_r + {{AW{1'b0}}, doWrite};
  wire logic [AW:0] wrGrayNxt = toGray(wrBinNxt);
  // full judged on the next pointer so ready is a clean flop; the
  // stale read pointer only ever understates the free room
  wire logic        fullNxt  = wrGrayNxt ==
    {~rdGrayS2_r[AW:AW-1], rdGrayS2_r[AW-2:0]};

  always_ff @(posedge wrClk) begin
    if (doWrite) begin
      mem[wrBin_r[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk) begin
    if (wrReset) begin
      wrBin_r    <= '0;
      wrGray_r   <= '0;
      rdGrayS1_r <= '0;
      rdGrayS2_r <= '0;
      wrReady_r  <= 1'b0;
    end else begin
      wrBin_r    <= wrBinNxt;
      wrGray_r   <= wrGrayNxt;
      rdGrayS1_r <= rdGray_r;
      rdGrayS2_r <= rdGrayS1_r;
      wrReady_r  <= ~fullNxt;
    end
  end

  // ****************************************************************
  // read side
  // ****************************************************************
  wire logic        doRead    = rdValid_r & rdReady;
  wire logic [AW:0] rdBinNxt  = rdBin_r + {{AW{1'b0}}, doRead};
  wire logic [AW:0] rdGrayNxt = toGray(rdBinNxt);
  wire logic        emptyNxt  = rdGrayNxt == wrGrayS2_r;

  always_ff @(posedge rdClk) begin
    if (rdReset) begin
      rdBin_r    <= '0;
      rdGray_r   <= '0;
      wrGrayS1_r <= '0;
      wrGrayS2_r <= '0;
      rdValid_r  <= 1'b0;
    end else begin
      rdBin_r    <= rdBinNxt;
      rdGray_r   <= rdGrayNxt;
      wrGrayS1_r <= wrGray_r;
      wrGrayS2_r <= wrGrayS1_r;
      rdValid_r  <= ~emptyNxt;
    end
  end

  assign wrReady = wrReady_r;
  assign rdValid = rdValid_r;
  assign rdData  = mem[rdBin_r[AW-1:0]];

endmodule

// File: rtl/slp_host.sv
// host around the lane port: feeds lane words, catches lane words, resets
`timescale 1ns/1ps
//
// Contract
// - one 64-bit receive word per lane is handed to the device.
// - in each lane word the msb is the earliest bit, bit 0 latest.
// - lane words change on the rising edge of the lane clock.
// - hold a lane reset whenever its clock is off frequency (no lock).
// - transmit reference clock is locked to the transceiver clocks.
// - transmit reference reset is high, synchronous, while clock bad.
// - user-side signals launch and sample on the core clock rise.
// - a free-running auxiliary clock near 75 MHz is supplied; this host has no auxiliary clock.
// - receive reset is high until core clock stable, synced per domain.
// - transmit reset is high until core clock stable, synced per domain.
//
module slp_host #(
  parameter int LANES         = slp_pkg::LANES_40G,
  parameter int VIRTUAL_LANES = slp_pkg::VIRTUAL_LANES,
  parameter int USER_W        = slp_pkg::USER_W_STRADDLE,
  parameter int DEPTH         = slp_pkg::FIFO_DEPTH,
  parameter int STABLE_CYCLES = slp_pkg::STABLE_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              linkClk,
  input  wire logic                              pllLocked,
  input  wire logic [LANES*slp_pkg::LANE_W-1:0]  userTxData,
  input  wire logic                              userTxValid,
  output logic                                   userTxReady,
  output logic      [LANES*slp_pkg::LANE_W-1:0]  userRxData,
  output logic                                   userRxValid,
  output logic                                   userRxOverflow,
  output logic                                   coreRxReset,
  output logic                                   coreTxReset,
  output logic      [LANES*slp_pkg::LANE_W-1:0]  rxSerdesData,
  output logic      [LANES-1:0]                  rxSerdesReset,
  output logic                                   txRefClkReset,
  input  wire logic [LANES*slp_pkg::LANE_W-1:0]  txSerdesData
);

  localparam int WORD_W = LANES * slp_pkg::LANE_W;

  // ****************************************************************
  // configuration checks
  // ****************************************************************
  generate
    if (LANES != slp_pkg::LANES_40G && LANES != slp_pkg::LANES_50G)
    begin : g_badLanes
      $error("slp_host: LANES must be 2 (50G) or 4 (40G)");
    end
    if (VIRTUAL_LANES != slp_pkg::VIRTUAL_LANES) begin : g_badVl
      $error("slp_host: virtual lane count must be 4");
    end
    if (USER_W != slp_pkg::USER_W_STRADDLE &&
        USER_W != slp_pkg::USER_W_WIDE) begin : g_badUser
      $error("slp_host: USER_W must be 128 or 256");
    end
    if (USER_W == slp_pkg::USER_W_WIDE &&
        LANES != slp_pkg::LANES_40G) begin : g_badWide
      $error("slp_host: 256-bit user bus only at 40G");
    end
    if (STABLE_CYCLES < 1 || STABLE_CYCLES >= (1 << slp_pkg::STABLE_CNT_W))
    begin : g_badStable
      $error("slp_host: STABLE_CYCLES out of counter range");
    end
  endgenerate

  // ****************************************************************
  // core clock domain: path resets held until the clock has settled
  // ****************************************************************
  localparam logic [slp_pkg::STABLE_CNT_W-1:0] STABLE_LAST =
    slp_pkg::STABLE_CNT_W'(STABLE_CYCLES);

  logic [slp_pkg::STABLE_CNT_W-1:0] stableCnt_r;
  logic                             coreRxReset_r;
  logic                             coreTxReset_r;

  wire logic stableDone = stableCnt_r == STABLE_LAST;
  wire logic [slp_pkg::STABLE_CNT_W-1:0] stableCntNxt =
    stableDone ? stableCnt_r : stableCnt_r + 1'b1;

  always_ff @(posedge clk) begin
    if (reset) begin
      stableCnt_r   <= '0;
      coreRxReset_r <= 1'b1;
      coreTxReset_r <= 1'b1;
    end else begin
      stableCnt_r   <= stableCntNxt;
      coreRxReset_r <= ~stableDone;
      coreTxReset_r <= ~stableDone;
    end
  end

  // ****************************************************************
  // link clock domain: reset and lock synchronisers
  // ****************************************************************
  // one recovered clock serves every lane and the tx reference, so the
  // reference is locked to the lane clocks by construction
  // the bench ties each lane clock of the device to linkClk, so
  // per-lane skew is not modelled
  logic linkRstS1_r;
  logic linkRstS2_r;
  logic lockS1_r;
  logic lockS2_r;
  logic rxRstS1_r;
  logic rxRstS2_r;
  logic txRstS1_r;
  logic txRstS2_r;

  always_ff @(posedge linkClk) begin
    linkRstS1_r <= reset;
    linkRstS2_r <= linkRstS1_r;
    lockS1_r    <= pllLocked;
    lockS2_r    <= lockS1_r;
    rxRstS1_r   <= coreRxReset_r;
    rxRstS2_r   <= rxRstS1_r;
    txRstS1_r   <= coreTxReset_r;
    txRstS2_r   <= txRstS1_r;
  end

  // lane clock is trusted only while the pll reports lock
  wire logic laneDown = linkRstS2_r | ~lockS2_r;

  logic [LANES-1:0] rxSerdesReset_r;
  logic             txRefClkReset_r;

  always_ff @(posedge linkClk) begin
    rxSerdesReset_r <= {LANES{laneDown}};
    txRefClkReset_r <= laneDown;
  end

  // ****************************************************************
  // toward the device: user words through the fifo onto the lanes
  // ****************************************************************
  logic              txfValid;
  logic [WORD_W-1:0] txfData;

  // nothing leaves while any receive reset is up, so the device never
  // sees a word that lands half inside a reset
  wire logic laneSendOk = ~laneDown & ~rxRstS2_r &
                          ~(|rxSerdesReset_r);

  slp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_txFifo (
    .wrClk   (clk),
    .wrReset (reset),
    .wrValid (userTxValid),
    .wrData  (userTxData),
    .wrReady (userTxReady),
    .rdClk   (linkClk),
    .rdReset (linkRstS2_r),
    .rdValid (txfValid),
    .rdData  (txfData),
    .rdReady (laneSendOk)
  );

  // user words already hold each lane in send order, msb first
  logic [WORD_W-1:0] laneWordNxt;
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign laneWordNxt[gl*slp_pkg::LANE_W +: slp_pkg::LANE_W] =
        (laneSendOk & txfValid) ?
          txfData[gl*slp_pkg::LANE_W +: slp_pkg::LANE_W] :
          slp_pkg::IDLE_WORD;
    end
  endgenerate

  logic [WORD_W-1:0] rxSerdesData_r;

  always_ff @(posedge linkClk) begin
    rxSerdesData_r <= laneWordNxt;
  end

  // ****************************************************************
  // from the device: lane words caught and handed to the core clock
  // ****************************************************************
  logic              rxfWrReady;
  logic              rxfValid;
  logic [WORD_W-1:0] rxfData;
  logic              overflowLink_r;

  // device transmit words are only meaningful once its tx path is out
  // of reset; anything the fifo cannot take sets a sticky overflow flag
  wire logic catchEn = ~laneDown & ~txRstS2_r;

  slp_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_rxFifo (
    .wrClk   (linkClk),
    .wrReset (linkRstS2_r),
    .wrValid (catchEn),
    .wrData  (txSerdesData),
    .wrReady (rxfWrReady),
    .rdClk   (clk),
    .rdReset (reset),
    .rdValid (rxfValid),
    .rdData  (rxfData),
    .rdReady (1'b1)
  );

  always_ff @(posedge linkClk) begin
    if (linkRstS2_r) begin
      overflowLink_r <= 1'b0;
    end else if (catchEn & ~rxfWrReady) begin
      overflowLink_r <= 1'b1;
    end
  end

  // ****************************************************************
  // core clock domain: outputs to user logic
  // ****************************************************************
  logic              ovfS1_r;
  logic              ovfS2_r;
  logic              userRxOverflow_r;
  logic [WORD_W-1:0] userRxData_r;
  logic              userRxValid_r;

  always_ff @(posedge clk) begin
    ovfS1_r <= overflowLink_r;
    ovfS2_r <= ovfS1_r;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      userRxValid_r    <= 1'b0;
      userRxData_r     <= '0;
      userRxOverflow_r <= 1'b0;
    end else begin
      userRxValid_r    <= rxfValid;
      userRxData_r     <= rxfData;
      userRxOverflow_r <= userRxOverflow_r | ovfS2_r;
    end
  end

  // ****************************************************************
  // output drive
  // ****************************************************************
  assign userRxData     = userRxData_r;
  assign userRxValid    = userRxValid_r;
  assign userRxOverflow = userRxOverflow_r;
  assign coreRxReset    = coreRxReset_r;
  assign coreTxReset    = coreTxReset_r;
  assign rxSerdesData   = rxSerdesData_r;
  assign rxSerdesReset  = rxSerdesReset_r;
  assign txRefClkReset  = txRefClkReset_r;

endmodule

// File: verification/slp_dev_model.sv
// device-side lane model: catches host lane words, sends a counted stream
`timescale 1ns/1ps
module slp_dev_model #(
  parameter int LANES = 4,
  parameter int W     = LANES*slp_pkg::LANE_W
) (
  input  wire logic             linkClk,
  input  wire logic [W-1:0]     rxSerdesData,
  input  wire logic [LANES-1:0] rxSerdesReset,
  input  wire logic             txRefClkReset,
  output logic      [W-1:0]     txSerdesData
);
  logic [W-1:0] got[$];
  logic [31:0]  seq = 32'h0;

  // ********
  // lane capture and counted send
  // ********
  // idle words are zero, so only nonzero words count as traffic
  always @(posedge linkClk) begin
    if (!rxSerdesReset[0] && rxSerdesData != '0)
      got.push_back(rxSerdesData);
    if (txRefClkReset)
      seq <= 32'h0;
    else
      seq <= seq + 32'h1;
  end

  always_comb begin
    for (int l = 0; l < LANES; l++)
      txSerdesData[l*64 +: 64] = {seq, 24'h0, 8'(l)};
  end
endmodule

// File: verification/slp_host_sva.sv
// checker of the lane port host, seen from its ports
`timescale 1ns/1ps
module slp_host_sva #(
  parameter int LANES         = 4,
  parameter int STABLE_CYCLES = 100,
  parameter int W             = LANES*slp_pkg::LANE_W
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             linkClk,
  input wire logic             pllLocked,
  input wire logic [W-1:0]     userTxData,
  input wire logic             userTxValid,
  input wire logic             userTxReady,
  input wire logic [W-1:0]     userRxData,
  input wire logic             userRxValid,
  input wire logic             userRxOverflow,
  input wire logic             coreRxReset,
  input wire logic             coreTxReset,
  input wire logic [W-1:0]     rxSerdesData,
  input wire logic [LANES-1:0] rxSerdesReset,
  input wire logic             txRefClkReset,
  input wire logic [W-1:0]     txSerdesData
);
  logic [15:0] relCnt;

  // ********
  // cycles since reset release
  // ********
  always_ff @(posedge clk) begin
    if (reset)
      relCnt <= 16'h0;
    else if (relCnt != 16'hffff)
      relCnt <= relCnt + 16'h1;
  end

  AST_TX_READY_RESET: assert property (@(posedge clk)
    reset |=> !userTxReady) else $error("tx ready during reset");
  AST_RX_VALID_RESET: assert property (@(posedge clk)
    reset |=> !userRxValid && userRxData == '0)
    else $error("rx valid during reset");
  AST_PATH_RESET_HELD: assert property (@(posedge clk)
    disable iff (reset) relCnt >= 16'h1 && relCnt < 16'(STABLE_CYCLES)
    |-> coreRxReset && coreTxReset) else $error("path reset dropped early");
  AST_PATH_RESET_DROP: assert property (@(posedge clk)
    disable iff (reset) relCnt >= 16'(STABLE_CYCLES + 2)
    |-> !coreRxReset && !coreTxReset) else $error("path reset stuck");
  AST_OVF_STICKY: assert property (@(posedge clk) disable iff (reset)
    userRxOverflow |=> userRxOverflow) else $error("overflow cleared");
  AST_RX_ONE_PER_WORD: assert property (@(posedge clk)
    disable iff (reset) userRxValid |=> !userRxValid)
    else $error("rx valid twice for one lane word");
  AST_LANE_RESETS_EQUAL: assert property (@(posedge linkClk)
    disable iff (reset) rxSerdesReset == {LANES{txRefClkReset}})
    else $error("lane resets differ");
  AST_IDLE_IN_LANE_RESET: assert property (@(posedge linkClk)
    disable iff (reset) rxSerdesReset[0] && $past(rxSerdesReset[0])
    |-> rxSerdesData == '0) else $error("lane word sent in lane reset");
  AST_LOCK_LOSS_RESET: assert property (@(posedge linkClk)
    disable iff (reset) !pllLocked [*4] |-> txRefClkReset)
    else $error("no lane reset on lock loss");
endmodule

bind slp_host slp_host_sva #(.LANES(LANES), .STABLE_CYCLES(STABLE_CYCLES)) CHK (
  .clk(clk), .reset(reset), .linkClk(linkClk), .pllLocked(pllLocked),
  .userTxData(userTxData), .userTxValid(userTxValid),
  .userTxReady(userTxReady), .userRxData(userRxData),
  .userRxValid(userRxValid), .userRxOverflow(userRxOverflow),
  .coreRxReset(coreRxReset), .coreTxReset(coreTxReset),
  .rxSerdesData(rxSerdesData), .rxSerdesReset(rxSerdesReset),
  .txRefClkReset(txRefClkReset), .txSerdesData(txSerdesData));

// File: verification/slp_host_test.sv
// self-checking bench of the lane port host against a device model
`timescale 1ns/1ps
module slp_host_test;
  localparam int L  = 4;
  localparam int SC = 4;
  localparam int W  = L*slp_pkg::LANE_W;
  logic         clk = 1'b0;
  logic         linkClk = 1'b0;
  logic         reset = 1'b1;
  logic         pllLocked = 1'b0;
  logic         userTxValid = 1'b0;
  logic [W-1:0] userTxData = '0;
  logic [W-1:0] userRxData, rxSerdesData, txSerdesData;
  logic         userTxReady, userRxValid, userRxOverflow;
  logic         coreRxReset, coreTxReset, txRefClkReset;
  logic [L-1:0] rxSerdesReset;
  logic [16:0]  lfsrState = 17'd73960;
  logic [31:0]  prevBase = 32'h0;
  logic [W-1:0] expQ[$];
  logic [W-1:0] d;
  int           n_errors = 0;
  int           n_tests = 0;
  int           nRx = 0;
  int           cnt;
  bit           ok;

  initial forever #5 clk = ~clk;
  // one lane clock doubles as the device's tx reference clock
  initial begin
    #37;
    forever #40 linkClk = ~linkClk;
  end

  slp_host #(.LANES(L), .STABLE_CYCLES(SC)) DUT (
    .clk(clk), .reset(reset), .linkClk(linkClk), .pllLocked(pllLocked),
    .userTxData(userTxData), .userTxValid(userTxValid),
    .userTxReady(userTxReady), .userRxData(userRxData),
    .userRxValid(userRxValid), .userRxOverflow(userRxOverflow),
    .coreRxReset(coreRxReset), .coreTxReset(coreTxReset),
    .rxSerdesData(rxSerdesData), .rxSerdesReset(rxSerdesReset),
    .txRefClkReset(txRefClkReset), .txSerdesData(txSerdesData));
  slp_dev_model #(.LANES(L)) DEV (
    .linkClk(linkClk), .rxSerdesData(rxSerdesData),
    .rxSerdesReset(rxSerdesReset), .txRefClkReset(txRefClkReset),
    .txSerdesData(txSerdesData));

  // ********
  // helpers
  // ********
  task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // each lane word is r then ~r, so it is never the idle word
  task automatic randWord(output logic [W-1:0] w);
    logic [31:0] r;
    for (int l = 0; l < L; l++) begin
      for (int b = 0; b < 32; b++) begin
        lfsrState = {lfsrState[15:0], lfsrState[16] ^ lfsrState[13]};
        r = {r[30:0], lfsrState[0]};
      end
      w[l*64 +: 64] = {r, ~r};
    end
  endtask

  // called at a falling edge; valid is left high for back-to-back use
  task automatic push(input logic [W-1:0] w, input int bound, output bit ok);
    ok = 0;
    userTxData = w;
    userTxValid = 1'b1;
    for (int i = 0; i < bound && !ok; i++) begin
      if (userTxReady === 1'b1)
        ok = 1;
      @(negedge clk);
    end
  endtask

  // ********
  // receive stream model: counted base, lane number in the low byte
  // ********
  always @(negedge clk) begin
    if (userRxValid === 1'b1) begin
      for (int l = 0; l < L; l++)
        check(W'(userRxData[l*64 +: 64]), W'({userRxData[63:32], 24'h0, 8'(l)}));
      if (prevBase != 32'h0 && userRxData[63:32] != 32'h0)
        check(W'(userRxData[63:32]), W'(prevBase + 32'h1));
      prevBase = userRxData[63:32];
      nRx++;
    end
  end

  initial begin
    // long enough for three lane clock edges inside reset
    repeat (30) @(negedge clk);
    check(W'(userTxReady), W'(1'b0));
    check(W'({coreRxReset, coreTxReset}), W'(2'b11));
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check(W'({coreRxReset, coreTxReset}), W'(2'b11));
    repeat (SC + 4) @(negedge clk);
    check(W'({coreRxReset, coreTxReset}), W'(2'b00));
    // lane clock unlocked: words must wait in the fifo until it refuses
    cnt = 0;
    for (int k = 0; k < 12; k++) begin
      randWord(d);
      push(d, 4, ok);
      if (!ok)
        break;
      expQ.push_back(d);
      cnt++;
    end
    userTxValid = 1'b0;
    check(W'(cnt), W'(slp_pkg::FIFO_DEPTH));
    check(W'(DEV.got.size()), W'(0));
    check(W'(rxSerdesReset), W'({L{1'b1}}));
    pllLocked = 1'b1;
    for (int k = 0; k < 20; k++) begin
      randWord(d);
      push(d, 400, ok);
      if (!ok) begin
        n_errors++;
        conclude();
      end
      expQ.push_back(d);
    end
    userTxValid = 1'b0;
    for (int i = 0; i < 3000 && DEV.got.size() < expQ.size(); i++)
      @(negedge clk);
    check(W'(DEV.got.size()), W'(expQ.size()));
    foreach (expQ[i])
      if (i < DEV.got.size())
        check(DEV.got[i], expQ[i]);
    check(W'(nRx > 20), W'(1'b1));
    check(W'(userRxOverflow), W'(1'b0));
    conclude();
  end
endmodule
